// ===== rtl/mb_responder.sv
// Request evaluation and reply generation of the serial slave
`timescale 1ns/10ps
module mb_responder
  import mb_resp_pkg::*;
#(
  parameter int DELAY_CYCLES = DELAY_STEP_CYCLES,
  parameter logic [15:0] COIL_COUNT = 16'h0020
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Received characters
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_error,
  // Characters to transmit
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_busy,
  // Configuration
  input wire logic [5:0] station_addr,
  input wire logic [15:0] char_cycles,
  input wire logic [15:0] extra_response_delay,
  // Parameter storage access
  output logic mem_req,
  output logic mem_write,
  output logic mem_coil,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire mem_fault_t mem_fault
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RECV,
    ST_CHECK,
    ST_ACCESS,
    ST_DELAY,
    ST_SEND,
    ST_CRC_HI,
    ST_CRC_LO
  } state_t;

  typedef struct packed {
    state_t state;
    logic [FRAME_BYTES-1:0][7:0] frame;
    logic [4:0] len;
    logic bad;
    logic [2:0] halves;
    logic [15:0] half_cnt;
    logic [15:0] crc;
    logic [15:0] crc_d1;
    logic [15:0] crc_d2;
    logic [15:0] base;
    logic [5:0] cnt;
    logic [5:0] idx;
    logic [4:0] tx_len;
    logic [4:0] send_idx;
    logic [15:0] tx_crc;
    logic [17:0] ms_cnt;
    logic [15:0] dly;
    logic req;
    logic wr;
    logic coil;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ctl_t;

  ctl_t r;
  ctl_t next_r;

  // ------------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------------
  // Length check; unknown functions pass so they can get code 01
  function automatic logic length_ok(input logic [7:0] fn,
                                     input logic [4:0] len,
                                     input logic [7:0] bc);
    if (fn == FN_READ_COILS || fn == FN_READ_REGS ||
        fn == FN_WRITE_COIL || fn == FN_WRITE_REG ||
        fn == FN_LOOPBACK) begin
      return len == FIXED_LEN;
    end else if (fn == FN_WRITE_COILS || fn == FN_WRITE_REGS) begin
      return {3'h0, len} == 8'(MULTI_HDR_LEN + bc);
    end
    return 1'b1;
  endfunction

  function automatic logic [7:0] request_exc(input logic [7:0] fn,
                                             input logic [15:0] start,
                                             input logic [15:0] word,
                                             input logic [7:0] bc);
    logic [15:0] nbytes;
    nbytes = (word + 16'h0007) >> 3;
    if (fn == FN_READ_COILS) begin
      if (word == '0 || word > MAX_COILS) return EXC_FORMAT;
    end else if (fn == FN_READ_REGS) begin
      if (word == '0 || word > MAX_REGS) return EXC_RANGE;
    end else if (fn == FN_WRITE_COIL) begin
      if ((word[15:8] != COIL_ON_HI && word[15:8] != COIL_LO) ||
          word[7:0] != COIL_LO) return EXC_FORMAT;
    end else if (fn == FN_WRITE_REG) begin
      return EXC_NONE;
    end else if (fn == FN_LOOPBACK) begin
      if (start != '0) return EXC_FORMAT;
    end else if (fn == FN_WRITE_COILS) begin
      if (word == '0 || word > MAX_COILS) return EXC_FORMAT;
      if ({8'h00, bc} != nbytes) return EXC_FORMAT;
    end else if (fn == FN_WRITE_REGS) begin
      if (word == '0 || word > MAX_REGS) return EXC_RANGE;
      if ({8'h00, bc} != (word << 1)) return EXC_FORMAT;
    end else begin
      return EXC_FUNCTION;
    end
    return EXC_NONE;
  endfunction

  // Storage answers mapped onto exception codes
  function automatic logic [7:0] fault_exc(input mem_fault_t f);
    case (f)
      FAULT_NO_ADDR: return EXC_ADDRESS;
      FAULT_RANGE: return EXC_RANGE;
      FAULT_LOCKED: return EXC_LOCKED;
      FAULT_ABNORMAL: return EXC_FORMAT;
      default: return EXC_NONE;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Check units and transmit buffer
  // ------------------------------------------------------------------
  logic [15:0] rx_crc_in;
  logic [15:0] rx_crc_next;
  logic [15:0] tx_crc_next;
  logic [7:0] push_data;
  logic push_valid;
  logic push_ready;

  assign rx_crc_in = (r.len == '0) ? CRC_INIT : r.crc;

  mb_crc_byte u_rx_crc (
    .crc_in(rx_crc_in),
    .data(rx_data),
    .crc_out(rx_crc_next)
  );

  mb_crc_byte u_tx_crc (
    .crc_in(r.tx_crc),
    .data(r.frame[r.send_idx[3:0]]),
    .crc_out(tx_crc_next)
  );

  mb_tx_buffer #(
    .WIDTH(8),
    .DEPTH(2)
  ) u_tx_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(push_valid),
    .in_data(push_data),
    .in_ready(push_ready),
    .out_valid(tx_valid),
    .out_data(tx_data),
    .out_ready(tx_ready)
  );

  // ------------------------------------------------------------------
  // Request decode
  // ------------------------------------------------------------------
  logic [7:0] fn;
  logic [15:0] word;
  logic [15:0] start;
  logic [7:0] bc;
  logic crc_ok;
  logic addr_ok;
  logic [7:0] exc;
  logic [15:0] cur_addr;
  logic line_busy;

  assign fn = r.frame[1];
  assign start = {r.frame[2], r.frame[3]};
  assign word = {r.frame[4], r.frame[5]};
  assign bc = r.frame[6];
  assign crc_ok = r.crc_d2 == {r.frame[4'(r.len - 5'h02)],
                               r.frame[4'(r.len - 5'h01)]};
  assign addr_ok = r.frame[0] == {2'h0, station_addr};
  assign exc = request_exc(fn, start, word, bc);
  assign cur_addr = 16'(r.base + {10'h000, r.idx});
  assign line_busy = rx_valid || tx_busy || tx_valid ||
                     r.state == ST_SEND || r.state == ST_CRC_HI ||
                     r.state == ST_CRC_LO;
  assign push_valid = r.state == ST_SEND || r.state == ST_CRC_HI ||
                      r.state == ST_CRC_LO;
  assign push_data = (r.state == ST_CRC_HI) ? r.tx_crc[15:8] :
                     (r.state == ST_CRC_LO) ? r.tx_crc[7:0] :
                     r.frame[r.send_idx[3:0]];
  assign mem_req = r.req;
  assign mem_write = r.wr;
  assign mem_coil = r.coil;
  assign mem_addr = r.addr;
  assign mem_wdata = r.wdata;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    next_r = r;

    // Silence measured in half characters, restarted by line activity
    if (line_busy) begin
      next_r.halves = '0;
      next_r.half_cnt = '0;
    end else if (r.halves != REST_HALF_CHARS) begin
      if (16'(r.half_cnt + 16'h0001) >= {1'b0, char_cycles[15:1]}) begin
        next_r.half_cnt = '0;
        next_r.halves = 3'(r.halves + 3'h1);
      end else begin
        next_r.half_cnt = 16'(r.half_cnt + 16'h0001);
      end
    end

    case (r.state)
      ST_RECV: begin
        if (rx_valid) begin
          // A frame that starts too soon is taken in but never answered
          if (r.len == '0) begin
            next_r.bad = rx_error ||
                         (r.halves != REST_HALF_CHARS);
          end else if (rx_error) begin
            next_r.bad = 1'b1;
          end
          if (r.len != 5'(FRAME_BYTES)) begin
            next_r.frame[r.len[3:0]] = rx_data;
            next_r.len = 5'(r.len + 5'h01);
          end else begin
            next_r.bad = 1'b1;
          end
          next_r.crc = rx_crc_next;
          next_r.crc_d1 = r.crc;
          next_r.crc_d2 = r.crc_d1;
        end else if (r.len != '0 && r.halves == REST_HALF_CHARS) begin
          next_r.state = ST_CHECK;
        end
      end

      ST_CHECK: begin
        next_r.len = '0;
        next_r.state = ST_RECV;
        next_r.idx = '0;
        next_r.base = start;
        next_r.cnt = 6'h01;
        if (r.bad || r.len < MIN_LEN || !crc_ok) begin
          next_r.state = ST_RECV;
        end else if (r.frame[0] == BROADCAST_ADDR || !addr_ok) begin
          next_r.state = ST_RECV;
        end else if (!length_ok(fn, r.len, bc)) begin
          next_r.state = ST_RECV;
        end else if (exc != EXC_NONE) begin
          next_r.frame[1] = fn | EXC_FLAG;
          next_r.frame[2] = exc;
          next_r.tx_len = EXC_LEN;
          next_r.state = ST_DELAY;
        end else if (fn == FN_LOOPBACK) begin
          next_r.tx_len = 5'(r.len - 5'h02);
          next_r.state = ST_DELAY;
        end else begin
          next_r.state = ST_ACCESS;
          next_r.tx_len = 5'(r.len - 5'h02);
          if (fn == FN_READ_COILS) begin
            next_r.cnt = word[5:0];
            next_r.frame[2] = 8'((word + 16'h0007) >> 3);
            next_r.tx_len = 5'(READ_HDR_LEN +
                               5'((word + 16'h0007) >> 3));
            for (int i = 3; i < 7; i++) begin
              next_r.frame[i] = '0;
            end
          end else if (fn == FN_READ_REGS) begin
            next_r.cnt = word[5:0];
            next_r.frame[2] = 8'(word << 1);
            next_r.tx_len = 5'(READ_HDR_LEN + 5'(word << 1));
          end else if (fn == FN_WRITE_COILS || fn == FN_WRITE_REGS) begin
            next_r.cnt = word[5:0];
          end
        end
      end

      ST_ACCESS: begin
        if (!r.req) begin
          if (r.idx == r.cnt) begin
            next_r.state = ST_DELAY;
          end else if (fn == FN_READ_COILS && cur_addr >= COIL_COUNT) begin
            next_r.idx = 6'(r.idx + 6'h01);
          end else begin
            next_r.req = 1'b1;
            next_r.addr = cur_addr;
            next_r.coil = fn == FN_READ_COILS || fn == FN_WRITE_COIL ||
                          fn == FN_WRITE_COILS;
            next_r.wr = fn == FN_WRITE_COIL || fn == FN_WRITE_REG ||
                        fn == FN_WRITE_COILS ||
                        fn == FN_WRITE_REGS;
            if (fn == FN_WRITE_COIL) begin
              next_r.wdata = {15'h0000, r.frame[4] == COIL_ON_HI};
            end else if (fn == FN_WRITE_COILS) begin
              next_r.wdata = {15'h0000,
                r.frame[4'(4'h7 + {1'b0, r.idx[5:3]})][r.idx[2:0]]};
            end else if (fn == FN_WRITE_REGS) begin
              next_r.wdata = {r.frame[4'(5'h07 + {r.idx[3:0], 1'b0})],
                              r.frame[4'(5'h08 + {r.idx[3:0], 1'b0})]};
            end else begin
              next_r.wdata = word;
            end
          end
        end else if (mem_ack) begin
          next_r.req = 1'b0;
          next_r.idx = 6'(r.idx + 6'h01);
          // Elements already written stay written; storage should
          // refuse a block up front where partial writes matter.
          if (fault_exc(mem_fault) != EXC_NONE) begin
            next_r.frame[1] = fn | EXC_FLAG;
            next_r.frame[2] = fault_exc(mem_fault);
            next_r.tx_len = EXC_LEN;
            next_r.state = ST_DELAY;
          end else if (fn == FN_READ_COILS) begin
            next_r.frame[4'(4'h3 + {1'b0, r.idx[5:3]})][r.idx[2:0]] =
              mem_rdata[0];
          end else if (fn == FN_READ_REGS) begin
            next_r.frame[4'(5'h03 + {r.idx[3:0], 1'b0})] =
              mem_rdata[15:8];
            next_r.frame[4'(5'h04 + {r.idx[3:0], 1'b0})] = mem_rdata[7:0];
          end
        end
      end

      ST_DELAY: begin
        // Rest time already elapsed when the frame end was seen
        if (r.dly == extra_response_delay) begin
          next_r.dly = '0;
          next_r.ms_cnt = '0;
          next_r.send_idx = '0;
          next_r.tx_crc = CRC_INIT;
          next_r.state = ST_SEND;
        end else if (r.ms_cnt == 18'(DELAY_CYCLES - 1)) begin
          next_r.ms_cnt = '0;
          next_r.dly = 16'(r.dly + 16'h0001);
        end else begin
          next_r.ms_cnt = 18'(r.ms_cnt + 18'h00001);
        end
      end

      ST_SEND: begin
        if (push_ready) begin
          next_r.tx_crc = tx_crc_next;
          next_r.send_idx = 5'(r.send_idx + 5'h01);
          if (r.send_idx == 5'(r.tx_len - 5'h01)) begin
            next_r.state = ST_CRC_HI;
          end
        end
      end

      ST_CRC_HI: begin
        if (push_ready) begin
          next_r.state = ST_CRC_LO;
        end
      end

      ST_CRC_LO: begin
        if (push_ready) begin
          next_r.state = ST_RECV;
        end
      end

      default: begin
        next_r.state = ST_RECV;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.state <= ST_RECV;
      r.halves <= RESET_HALVES;
      r.crc <= CRC_INIT;
      r.tx_crc <= CRC_INIT;
    end else begin
      r <= next_r;
    end
  end
endmodule // mb_responder

// ===== rtl/mb_resp_pkg.sv
// Shared constants and types of the serial request responder
package mb_resp_pkg;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  // One step of the extra response delay, in ns
  localparam int DELAY_STEP_NS = 1000000;
  localparam int DELAY_STEP_CYCLES = DELAY_STEP_NS / CLK_PERIOD_NS;
  // Rest period of 3.5 characters, counted in half characters
  localparam logic [2:0] REST_HALF_CHARS = 3'h7;
  localparam logic [2:0] RESET_HALVES = 3'h7;

  // ------------------------------------------------------------------
  // Frame layout
  // ------------------------------------------------------------------
  localparam int FRAME_BYTES = 16;
  localparam logic [4:0] FIXED_LEN = 5'h08;
  localparam logic [4:0] MULTI_HDR_LEN = 5'h09;
  localparam logic [4:0] MIN_LEN = 5'h04;
  localparam logic [4:0] EXC_LEN = 5'h03;
  localparam logic [4:0] READ_HDR_LEN = 5'h03;
  localparam logic [15:0] MAX_COILS = 16'h0020;
  localparam logic [15:0] MAX_REGS = 16'h0004;
  localparam logic [7:0] COIL_ON_HI = 8'hFF;
  localparam logic [7:0] COIL_LO = 8'h00;

  // ------------------------------------------------------------------
  // CRC
  // ------------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REFL = 16'hA001;

  // ------------------------------------------------------------------
  // Function and exception codes
  // ------------------------------------------------------------------
  localparam logic [7:0] FN_READ_COILS = 8'h01;
  localparam logic [7:0] FN_READ_REGS = 8'h03;
  localparam logic [7:0] FN_WRITE_COIL = 8'h05;
  localparam logic [7:0] FN_WRITE_REG = 8'h06;
  localparam logic [7:0] FN_LOOPBACK = 8'h08;
  localparam logic [7:0] FN_WRITE_COILS = 8'h0F;
  localparam logic [7:0] FN_WRITE_REGS = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ADDRESS = 8'h02;
  localparam logic [7:0] EXC_FORMAT = 8'h03;
  localparam logic [7:0] EXC_RANGE = 8'h21;
  localparam logic [7:0] EXC_LOCKED = 8'h22;
  localparam logic [7:0] BROADCAST_ADDR = 8'h00;

  // Answer of the parameter storage to one access
  typedef enum logic [2:0] {
    FAULT_NONE,
    FAULT_NO_ADDR,
    FAULT_RANGE,
    FAULT_LOCKED,
    FAULT_ABNORMAL
  } mem_fault_t;
endpackage

// ===== rtl/mb_crc_byte.sv
// One byte step of the reflected 16-bit frame check
`timescale 1ns/10ps
module mb_crc_byte
  import mb_resp_pkg::*;
(
  // Running value and byte
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data,
  // Updated value
  output logic [15:0] crc_out
);
  always_comb begin
    logic [15:0] c;
    c = crc_in ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
    end
    crc_out = c;
  end
endmodule // mb_crc_byte

// ===== rtl/mb_tx_buffer.sv
// Small valid/ready buffer in front of the character transmitter
`timescale 1ns/10ps
module mb_tx_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
  } fifo_t;

  fifo_t r;
  fifo_t next_r;
  logic push;
  logic pop;

  assign in_ready = (r.count != CW'(DEPTH));
  assign out_valid = (r.count != '0);
  assign out_data = r.mem[r.rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wptr] = in_data;
      next_r.wptr = (r.wptr == PW'(DEPTH - 1)) ? '0 : PW'(r.wptr + 1'b1);
    end
    if (pop) begin
      next_r.rptr = (r.rptr == PW'(DEPTH - 1)) ? '0 : PW'(r.rptr + 1'b1);
    end
    if (push && !pop) begin
      next_r.count = CW'(r.count + 1'b1);
    end else if (pop && !push) begin
      next_r.count = CW'(r.count - 1'b1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule // mb_tx_buffer

// ===== bench/mb_responder_properties.sv
// Port-level properties of the request responder
`timescale 1ns/10ps
module mb_responder_properties
  import mb_resp_pkg::*;
#(
  parameter int DELAY_CYCLES = 4
) (
  // Clock, reset, receive
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_error,
  // Transmit
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  // Configuration and storage
  input wire logic [5:0] station_addr,
  input wire logic [15:0] char_cycles,
  input wire logic [15:0] extra_response_delay,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic mem_coil,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_ack
);
  // ----
  // Silence since the last received byte
  // ----
  logic [31:0] quiet, rest;
  logic sent, framed;
  logic [7:0] frame_addr;
  assign rest = 32'(char_cycles[15:1]) * 32'h7;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      quiet <= 32'hFFFFFFFF;
      sent <= 1'b0;
      framed <= 1'b0;
      frame_addr <= 8'h00;
    end else begin
      quiet <= rx_valid ? 32'h0 : quiet + 32'(quiet != 32'hFFFFFFFF);
      sent <= !rx_valid && (sent || (tx_valid && tx_ready));
      framed <= framed || (rx_valid && quiet >= rest);
      if (rx_valid && quiet >= rest)
        frame_addr <= rx_data;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----
  // Properties
  // ----
  AST_REST_BEFORE_REPLY: assert property (
    tx_valid && !sent |->
    quiet >= rest + 32'(extra_response_delay) * DELAY_CYCLES)
    else $error("reply started too early");
  AST_TX_HOLD: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("pending character changed");
  AST_MEM_HOLD: assert property (
    mem_req && !mem_ack |=>
    mem_req && $stable({mem_write, mem_coil, mem_addr, mem_wdata}))
    else $error("storage request not held");
  AST_MEM_RELEASE: assert property (
    mem_ack |=> !mem_req)
    else $error("storage request kept after acknowledge");
  AST_REPLY_ADDR: assert property (
    tx_valid && tx_ready && !sent |-> tx_data == {2'h0, station_addr})
    else $error("reply does not start with own address");
  AST_BCAST_SILENT: assert property (
    framed && frame_addr == BROADCAST_ADDR |-> !mem_req && !tx_valid)
    else $error("broadcast acted upon");
  AST_FOREIGN_SILENT: assert property (
    framed && frame_addr != {2'h0, station_addr} |-> !mem_req && !tx_valid)
    else $error("foreign frame acted upon");
  AST_ACCESS_AFTER_END: assert property (
    $rose(mem_req) |-> quiet >= rest)
    else $error("storage access before frame end");
  cover property (mem_req && mem_write && mem_ack);
  cover property (mem_req && mem_coil && mem_ack);
  cover property (rx_valid && rx_error);
endmodule // mb_responder_properties

bind mb_responder mb_responder_properties #(.DELAY_CYCLES(DELAY_CYCLES)) u_p (
  .*);

// ===== bench/mb_far_side.sv
// Far side stand-in: transmitter, reply sink and parameter storage
`timescale 1ns/10ps
module mb_far_side
  import mb_resp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Transmit side
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic tx_busy,
  input wire logic [15:0] char_cycles,
  // Storage side
  input wire logic mem_req,
  input wire logic mem_coil,
  input wire logic [15:0] mem_addr,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  output mem_fault_t mem_fault,
  input wire mem_fault_t inject
);
  logic [7:0] got[$];
  int busy;
  int lat;
  logic stall;
  function automatic logic coil_of(input logic [15:0] a);
    return a[0] ^ a[2];
  endfunction
  function automatic logic [15:0] reg_of(input logic [15:0] a);
    return a ^ 16'hA5C3;
  endfunction
  assign tx_ready = busy == 0 && !stall;
  assign tx_busy = busy != 0;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 0;
      stall <= 1'b0;
      lat <= 0;
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0000;
      mem_fault <= FAULT_NONE;
    end else begin
      // Random stalls let the two-entry buffer fill up
      stall <= $urandom_range(2, 0) == 0;
      busy <= tx_valid && tx_ready ? char_cycles : busy - (busy != 0);
      if (tx_valid && tx_ready)
        got.push_back(tx_data);
      // Answer lines carry garbage outside the acknowledge cycle
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      mem_fault <= FAULT_RANGE;
      if (mem_req && !mem_ack && lat == 0) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem_coil ? {15'h0, coil_of(mem_addr)} : reg_of(mem_addr);
        mem_fault <= inject;
        lat <= $urandom_range(2, 0);
      end else if (mem_req && !mem_ack)
        lat <= lat - 1;
    end
  end
endmodule // mb_far_side

// ===== bench/mb_responder_tb.sv
// Self-checking bench of the request responder
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module mb_responder_tb
  import mb_resp_pkg::*;
;
  typedef logic [7:0] bytes_t[$];
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] rx_data = 8'h00;
  logic rx_valid = 1'b0;
  logic rx_error = 1'b0;
  logic [5:0] st = 6'h08;
  logic [15:0] extra = 16'h0000;
  mem_fault_t inject = FAULT_NONE;
  logic [7:0] tx_data;
  logic tx_valid, tx_ready, tx_busy, mem_req, mem_write, mem_coil, mem_ack;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  mem_fault_t mem_fault;
  int errors = 0;
  int checked = 0;
  bytes_t none;
  always #2 clk = ~clk;
  mb_responder #(.DELAY_CYCLES(4)) u_mb_responder (.*, .station_addr(st),
    .char_cycles(16'h0008), .extra_response_delay(extra));
  mb_far_side u_mb_far_side (.*, .char_cycles(16'h0008));
  // ----
  // Expectations
  // ----
  function automatic logic [15:0] crc16(input bytes_t b);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
    end
    return c;
  endfunction
  function automatic bytes_t req(input logic [7:0] fn,
                                 input logic [15:0] a, input logic [15:0] b);
    return '{{2'h0, st}, fn, a[15:8], a[7:0], b[15:8], b[7:0]};
  endfunction
  function automatic bytes_t exc(input logic [7:0] fn, input logic [7:0] cd);
    return '{{2'h0, st}, fn | EXC_FLAG, cd};
  endfunction
  function automatic bytes_t coil_resp(input logic [15:0] s, input int n);
    bytes_t r;
    logic [7:0] b;
    logic [15:0] a;
    r = '{{2'h0, st}, FN_READ_COILS, 8'((n + 7) / 8)};
    for (int i = 0; i < n; i += 8) begin
      b = 8'h00;
      for (int k = 0; k < 8 && i + k < n; k++) begin
        a = s + 16'(i + k);
        b[k] = a < 16'h0020 && u_mb_far_side.coil_of(a);
      end
      r.push_back(b);
    end
    return r;
  endfunction
  function automatic bytes_t reg_resp(input logic [15:0] s, input int n);
    bytes_t r;
    logic [15:0] v;
    r = '{{2'h0, st}, FN_READ_REGS, 8'(2 * n)};
    for (int i = 0; i < n; i++) begin
      v = u_mb_far_side.reg_of(s + 16'(i));
      r = {r, v[15:8], v[7:0]};
    end
    return r;
  endfunction
  // ----
  // Drivers and checks
  // ----
  task automatic send(input bytes_t f, input int fault);
    logic [15:0] c;
    c = crc16(f) ^ 16'(fault == 1);
    f = {f, c[15:8], c[7:0]};
    extra = 16'($urandom_range(2, 0));
    foreach (f[i]) begin
      @(negedge clk);
      rx_data = f[i];
      rx_valid = 1'b1;
      rx_error = fault == 2 && i == 1;
      @(negedge clk);
      rx_valid = 1'b0;
      rx_error = 1'b0;
      rx_data = ~rx_data;
      repeat (2) @(negedge clk);
    end
  endtask
  task automatic expect_reply(input bytes_t e, input int gap);
    logic [15:0] c;
    c = crc16(e);
    if (e.size() != 0) e = {e, c[15:8], c[7:0]};
    for (int n = 0; n < 1500; n++) begin
      if (e.size() != 0 && u_mb_far_side.got.size() >= e.size())
        break;
      @(negedge clk);
    end
    `CHK("reply length", e.size(), u_mb_far_side.got.size())
    foreach (e[i])
      if (i < u_mb_far_side.got.size())
        `CHK("reply byte", e[i], u_mb_far_side.got[i])
    u_mb_far_side.got.delete();
    repeat (gap) @(negedge clk);
  endtask
  task automatic txn(input bytes_t r, input bytes_t e, input int fault);
    send(r, fault);
    expect_reply(e, 40);
  endtask
  task automatic report_and_stop();
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    bytes_t r;
    logic [15:0] s;
    int n;
    mem_fault_t fl[3] = '{FAULT_NO_ADDR, FAULT_RANGE, FAULT_LOCKED};
    logic [7:0] cd[3] = '{EXC_ADDRESS, EXC_RANGE, EXC_LOCKED};
    logic [7:0] xf[6] = '{8'h01, 8'h01, 8'h03, 8'h07, 8'h05, 8'h08};
    logic [7:0] xc[6] = '{8'h03, 8'h03, 8'h21, 8'h01, 8'h03, 8'h03};
    logic [15:0] xb[6] = '{16'h0000, 16'h0021, 16'h0005, 16'h0001, 16'h1234,
      16'h0000};
    void'($urandom(32'hCE77));
    st = 6'($urandom_range(32, 1));
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) begin
      s = 16'($urandom_range(40, 0));
      n = $urandom_range(32, 1);
      txn(req(FN_READ_COILS, s, 16'(n)), coil_resp(s, n), 0);
      s = 16'($urandom_range(60, 0));
      n = $urandom_range(4, 1);
      txn(req(FN_READ_REGS, s, 16'(n)), reg_resp(s, n), 0);
    end
    txn(req(FN_READ_COILS, 16'h001C, 16'h000C), coil_resp(16'h001C, 12),
        0);
    foreach (xf[i])
      txn(req(xf[i], 16'(i > 3), xb[i]), exc(xf[i], xc[i]),
          0);
    r = req(FN_LOOPBACK, 16'h0000, 16'($urandom));
    txn(r, r, 0);
    r = req(FN_WRITE_REG, 16'($urandom_range(60, 0)), 16'($urandom));
    txn(r, r, 0);
    `CHK("storage write", {1'b1, r[4], r[5]}, {mem_write, mem_wdata})
    r = req(FN_WRITE_COIL, 16'h0003, 16'hFF00);
    txn(r, r, 0);
    r = req(FN_WRITE_COILS, 16'h0002, 16'h000A);
    r = {r, 8'h02, 8'($urandom), 8'h03};
    txn(r, r, 0);
    r = req(FN_WRITE_REGS, 16'h0004, 16'h0002);
    r = {r, 8'h04, 8'($urandom), 8'h5A, 8'hC3, 8'($urandom)};
    txn(r, r, 0);
    foreach (fl[i]) begin
      inject = fl[i];
      txn(req(FN_WRITE_REG, 16'h0010, 16'h0001), exc(FN_WRITE_REG, cd[i]),
          0);
    end
    inject = FAULT_ABNORMAL;
    txn(req(FN_READ_COILS, 16'h0000, 16'h0004),
        exc(FN_READ_COILS, EXC_FORMAT), 0);
    inject = FAULT_NONE;
    r = req(FN_WRITE_REG, 16'h0010, 16'h0001);
    r[0] = 8'h00;
    txn(r, none, 0);
    r[0] = {2'h0, st} + 8'h01;
    txn(r, none, 0);
    r[0] = {2'h0, st};
    txn(r, none, 1);
    txn(r, none, 2);
    r.push_back(8'h00);
    txn(r, none, 0);
    r = req(FN_READ_COILS, 16'h0000, 16'h0004);
    send(r, 0);
    expect_reply(coil_resp(16'h0000, 4), 0);
    txn(r, none, 0);
    report_and_stop();
  end
  initial begin
    // About thirty transfers of at most two thousand cycles each
    repeat (90000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule // mb_responder_tb
